/* nvm_pkg.sv */
// package: constants and carriers for the nonvolatile access controller
`default_nettype none
package nvm_pkg;
    localparam int          MODULES       = 4;
    localparam int          ADDR_W        = 24;
    localparam int          DATA_W        = 32;
    localparam int          PAGE_BYTES    = 128;
    localparam int          CLK_MHZ       = 200;
    localparam int          PROG_MAX_US   = 3500;
    localparam int          ERASE_MAX_US  = 8000;
    localparam int          PROG_CYCLES   = PROG_MAX_US * CLK_MHZ;
    localparam int          ERASE_CYCLES  = ERASE_MAX_US * CLK_MHZ;
    localparam int          CNT_W         = 24;
    localparam int          MOD_LSB       = 22;
    localparam logic [2:0]  WAIT_RESET    = 3'h4;
    localparam logic [2:0]  WAIT_FLOOR    = 3'h1;
    localparam logic [1:0]  SHARED_MODULE = 2'h3;
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;

    typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ERASE_SECT, OP_ERASE_PAGE} nvm_op_e;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } rd_req_s;

    typedef struct packed {
        logic              valid;
        nvm_op_e           op;
        logic [1:0]        target;
    } pe_req_s;
endpackage
`default_nettype wire

/* nvm_access_ctrl.sv */
// nonvolatile array access, prefetch, wait states and program/erase sequencing
//
// Operation
// - array reads as erased and unprotected after delivery.
// - page program on 128 bytes completes within 3.5 ms.
// - sector or page erase completes within 8 ms.
// - durations come from the timing tick plus a few system cycles.
// - reads from other modules allow only module 3 busy.
// - up to 3 modules busy if reads stay in one module, all 4 if reads come from RAM.
// - module delivering reads is never programmed or erased.
// - all accesses go through the on-chip memory bus port here.
// - prefetch fetches ahead for sequential read streams.
// - wait states only for non-sequential reads.
// - 3-bit wait field gives the wait-state count directly, except 0 acts as 1.
`timescale 1ns/1ps
`default_nettype none
module nvm_access_ctrl #(
    parameter int PROG_CYCLES  = nvm_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = nvm_pkg::ERASE_CYCLES
) (
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    input  wire logic                        clk_en,
    input  wire logic [2:0]                  nvm_wait_cycles,
    input  wire logic                        rd_from_ram,
    input  wire nvm_pkg::rd_req_s            rd_req,
    output logic                             rd_ready,
    output logic [nvm_pkg::DATA_W-1:0]       rd_data,
    input  wire nvm_pkg::pe_req_s            pe_req,
    input  wire logic                        timing_tick,
    output logic                             pe_accept,
    output logic                             pe_reject,
    output logic [nvm_pkg::MODULES-1:0]      busy
);
    typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_DONE} rd_state_e;

    function automatic logic [1:0] mod_of(input logic [nvm_pkg::ADDR_W-1:0] a);
        return a[nvm_pkg::MOD_LSB +: 2];
    endfunction

    // two-stage sync of the timing source
    logic tick_s1_reg, tick_s2_reg, tick_s3_reg;
    logic tick_pulse;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_s1_reg <= 1'b0;
            tick_s2_reg <= 1'b0;
            tick_s3_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            tick_s1_reg <= timing_tick;
            tick_s2_reg <= tick_s1_reg;
            tick_s3_reg <= tick_s2_reg;
        end
    end
    assign tick_pulse = tick_s2_reg & ~tick_s3_reg;

    // read path
    rd_state_e                  rd_st_reg, rd_st_next;
    logic [2:0]                 wcnt_reg, wcnt_next;
    logic [nvm_pkg::ADDR_W-1:0] next_addr_reg, next_addr_next;
    logic                       pf_valid_reg, pf_valid_next;
    logic                       rd_ready_reg, rd_ready_next;
    logic [1:0]                 rd_mod_reg, rd_mod_next;
    logic                       rd_active_reg, rd_active_next;
    logic [nvm_pkg::DATA_W-1:0] rd_data_reg, rd_data_next;
    logic [2:0]                 eff_wait;
    logic                       seq_hit;

    assign eff_wait = (nvm_wait_cycles == 3'h0) ? nvm_pkg::WAIT_FLOOR
                                                : nvm_wait_cycles;
    assign seq_hit  = pf_valid_reg && (rd_req.addr == next_addr_reg);

    always_comb
    begin
        rd_st_next     = rd_st_reg;
        wcnt_next      = wcnt_reg;
        next_addr_next = next_addr_reg;
        pf_valid_next  = pf_valid_reg;
        rd_ready_next  = 1'b0;
        rd_mod_next    = rd_mod_reg;
        rd_active_next = rd_active_reg;
        rd_data_next   = nvm_pkg::ERASED_WORD;
        case (rd_st_reg)
            RD_IDLE:
            begin
                if (rd_req.valid)
                begin
                    rd_mod_next    = mod_of(rd_req.addr);
                    rd_active_next = 1'b1;
                    next_addr_next = nvm_pkg::ADDR_W'(rd_req.addr + nvm_pkg::ADDR_W'(4));
                    if (seq_hit)
                    begin
                        rd_ready_next = 1'b1;
                        rd_st_next    = RD_DONE;
                    end
                    else
                    begin
                        wcnt_next  = eff_wait;
                        rd_st_next = RD_WAIT;
                    end
                end
            end
            RD_WAIT:
            begin
                if (wcnt_reg == 3'h1)
                begin
                    rd_ready_next = 1'b1;
                    pf_valid_next = 1'b1;
                    rd_st_next    = RD_DONE;
                end
                else
                begin
                    wcnt_next = wcnt_reg - 3'h1;
                end
            end
            default:
            begin
                rd_st_next = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_st_reg     <= RD_IDLE;
            wcnt_reg      <= 3'h0;
            next_addr_reg <= '0;
            pf_valid_reg  <= 1'b0;
            rd_ready_reg  <= 1'b0;
            rd_mod_reg    <= 2'h0;
            rd_active_reg <= 1'b0;
            rd_data_reg   <= nvm_pkg::ERASED_WORD;
        end
        else if (clk_en)
        begin
            rd_st_reg     <= rd_st_next;
            wcnt_reg      <= wcnt_next;
            next_addr_reg <= next_addr_next;
            pf_valid_reg  <= pf_valid_next;
            rd_ready_reg  <= rd_ready_next;
            rd_mod_reg    <= rd_mod_next;
            rd_active_reg <= rd_active_next;
            rd_data_reg   <= rd_data_next;
        end
    end
    assign rd_ready = rd_ready_reg;
    assign rd_data  = rd_data_reg;

    // program / erase engines, one per module
    logic [nvm_pkg::MODULES-1:0]            busy_reg, busy_next;
    logic [nvm_pkg::CNT_W-1:0]              ticks_reg [nvm_pkg::MODULES];
    logic [nvm_pkg::CNT_W-1:0]              ticks_next [nvm_pkg::MODULES];
    logic                                   acc_reg, acc_next, rej_reg, rej_next;
    logic                                   allowed;

    always_comb
    begin
        allowed = 1'b1;
        if (rd_active_reg && !rd_from_ram && rd_req.valid && mod_of(rd_req.addr) != rd_mod_reg)
        begin
            // reads span modules: only module 3, alone
            allowed = (pe_req.target == nvm_pkg::SHARED_MODULE) && (busy_reg == '0);
        end
        if (rd_active_reg && !rd_from_ram && pe_req.target == rd_mod_reg)
        begin
            allowed = 1'b0;
        end
        if (busy_reg[pe_req.target])
        begin
            allowed = 1'b0;
        end
    end

    always_comb
    begin
        busy_next = busy_reg;
        acc_next  = 1'b0;
        rej_next  = 1'b0;
        for (int i = 0; i < nvm_pkg::MODULES; i++)
        begin
            ticks_next[i] = ticks_reg[i];
            if (busy_reg[i])
            begin
                if (ticks_reg[i] <= nvm_pkg::CNT_W'(1))
                begin
                    busy_next[i] = 1'b0;
                end
                else if (tick_pulse)
                begin
                    ticks_next[i] = ticks_reg[i] - nvm_pkg::CNT_W'(1);
                end
            end
        end
        if (pe_req.valid && pe_req.op != nvm_pkg::OP_NONE)
        begin
            if (allowed)
            begin
                acc_next = 1'b1;
                busy_next[pe_req.target] = 1'b1;
                ticks_next[pe_req.target] = (pe_req.op == nvm_pkg::OP_PROG)
                    ? nvm_pkg::CNT_W'(PROG_CYCLES) : nvm_pkg::CNT_W'(ERASE_CYCLES);
            end
            else
            begin
                rej_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy_reg <= '0;
            acc_reg  <= 1'b0;
            rej_reg  <= 1'b0;
            for (int i = 0; i < nvm_pkg::MODULES; i++)
            begin
                ticks_reg[i] <= '0;
            end
        end
        else if (clk_en)
        begin
            busy_reg <= busy_next;
            acc_reg  <= acc_next;
            rej_reg  <= rej_next;
            for (int i = 0; i < nvm_pkg::MODULES; i++)
            begin
                ticks_reg[i] <= ticks_next[i];
            end
        end
    end
    assign busy      = busy_reg;
    assign pe_accept = acc_reg;
    assign pe_reject = rej_reg;

    // checks
    a_wait_floor: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clk_en && rd_st_reg == RD_IDLE && rd_req.valid && !seq_hit |=> wcnt_reg != 3'h0)
        else $error("wait count zero");
    a_seq_fast: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clk_en && rd_st_reg == RD_IDLE && rd_req.valid && seq_hit |=> rd_ready_reg)
        else $error("sequential read delayed");
    a_nonseq_wait: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clk_en && rd_st_reg == RD_IDLE && rd_req.valid && !seq_hit |=> !rd_ready_reg)
        else $error("non-sequential read without wait");
    a_pf_fill: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_ready_reg |-> pf_valid_reg)
        else $error("prefetch not armed");
    a_erased_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rd_ready_reg |-> rd_data == nvm_pkg::ERASED_WORD)
        else $error("array not erased");
    a_busy_start: assert property (@(posedge sys_clk) disable iff (!arst_n)
        acc_reg |-> busy_reg != '0)
        else $error("accepted op not busy");
    a_rd_target: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clk_en && pe_req.valid && rd_active_reg && !rd_from_ram
        && pe_req.target == rd_mod_reg |=> !acc_reg)
        else $error("read module targeted");
    a_one_shared: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clk_en && pe_req.valid && rd_active_reg && !rd_from_ram && rd_req.valid
        && mod_of(rd_req.addr) != rd_mod_reg
        && pe_req.target != nvm_pkg::SHARED_MODULE |=> !acc_reg)
        else $error("non-shared module accepted");
    a_excl: assert property (@(posedge sys_clk) disable iff (!arst_n)
        acc_reg && rej_reg |-> 1'b0)
        else $error("accept and reject together");
    c_seq_read: cover property (@(posedge sys_clk) disable iff (!arst_n)
        rd_req.valid && seq_hit);
    c_prog: cover property (@(posedge sys_clk) disable iff (!arst_n)
        pe_req.valid && pe_req.op == nvm_pkg::OP_PROG ##1 acc_reg);
    c_reject: cover property (@(posedge sys_clk) disable iff (!arst_n) rej_reg);
    c_all_busy: cover property (@(posedge sys_clk) disable iff (!arst_n) &busy_reg);
endmodule
`default_nettype wire

/* nvm_bus_master.sv */
// memory bus read master model
`timescale 1ns/1ps
`default_nettype none
module nvm_bus_master (
    input  wire logic            sys_clk,
    input  wire logic            rd_ready,
    output var nvm_pkg::rd_req_s rd_req
);
    initial rd_req = '0;

    // hold request until answered, then release with scrambled address
    task automatic do_read(input logic [23:0] addr, output int lat);
        lat = 0;
        @(posedge sys_clk);
        rd_req <= '{valid: 1'b1, addr: addr};
        do
        begin
            @(posedge sys_clk);
            lat++;
        end
        while (rd_ready !== 1'b1 && lat < 100);
        rd_req <= '{valid: 1'b0, addr: ~addr};
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* tb_flash_access_and_program_ctrl.sv */
// testbench for the nonvolatile access controller
`timescale 1ns/1ps
`default_nettype none
module tb_flash_access_and_program_ctrl;
    localparam int    TICKS = 4;
    localparam int    TPER  = 6;
    localparam int    SPAN_LO = TPER * (TICKS - 2) + 2;
    localparam int    SPAN_HI = TPER * (TICKS - 1) + 1;
    logic             sys_clk;
    logic             arst_n;
    logic             rd_from_ram;
    logic             timing_tick;
    logic             clk_en;
    logic [2:0]       nvm_wait_cycles;
    nvm_pkg::rd_req_s rd_req;
    nvm_pkg::pe_req_s pe_req;
    logic             rd_ready;
    logic             pe_accept;
    logic             pe_reject;
    logic [31:0]      rd_data;
    logic [3:0]       busy;
    int               miscompares;
    int               cmp_count;
    int               seed;
    int               lat;
    int               tdiv;
    int               w;
    logic [23:0]      a;
    int               run_len [4];
    int               busy_len [4];

    nvm_access_ctrl #(.PROG_CYCLES(TICKS), .ERASE_CYCLES(TICKS)) DUT (
        .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .nvm_wait_cycles(nvm_wait_cycles), .rd_from_ram(rd_from_ram),
        .rd_req(rd_req), .rd_ready(rd_ready), .rd_data(rd_data), .pe_req(pe_req),
        .timing_tick(timing_tick), .pe_accept(pe_accept), .pe_reject(pe_reject),
        .busy(busy));
    nvm_bus_master master (.sys_clk(sys_clk), .rd_ready(rd_ready), .rd_req(rd_req));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // free running timing source, one rise every 6 cycles
    always @(posedge sys_clk)
    begin
        tdiv <= (tdiv == 2) ? 0 : tdiv + 1;
        if (tdiv == 2)
            timing_tick <= ~timing_tick;
    end

    // length of the last busy period per module
    always @(posedge sys_clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (busy[i] === 1'b1)
                run_len[i] <= run_len[i] + 1;
            else if (run_len[i] != 0)
            begin
                busy_len[i] <= run_len[i];
                run_len[i]  <= 0;
            end
        end
    end

    function automatic logic [31:0] span_ok(input int n);
        return {31'h0, n >= SPAN_LO && n <= SPAN_HI};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic int exp_lat(input int wc, input bit seq);
        return 1 + (seq ? 1 : ((wc == 0) ? 1 : wc) + 1);
    endfunction

    task automatic pe_op(input logic [1:0] op, input logic [1:0] t, input logic acc);
        @(posedge sys_clk);
        pe_req <= '{valid: 1'b1, op: nvm_pkg::nvm_op_e'(op), target: t};
        @(posedge sys_clk);
        pe_req <= '{valid: 1'b0, op: nvm_pkg::OP_NONE, target: 2'h0};
        @(posedge sys_clk);
        check("pe_accept", {31'h0, pe_accept}, {31'h0, acc});
        check("pe_reject", {31'h0, pe_reject}, {31'h0, ~acc});
    endtask

    // returns cycles until busy of target clears
    task automatic drain(input logic [1:0] t, output int n);
        n = 0;
        while (busy[t] === 1'b1 && n < 200)
        begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        miscompares++;
        complete_run;
    end

    initial
    begin
        seed = 32'h44c4f72e;
        miscompares = 0;
        cmp_count = 0;
        tdiv = 0;
        timing_tick = 1'b0;
        clk_en = 1'b1;
        run_len = '{0, 0, 0, 0};
        busy_len = '{0, 0, 0, 0};
        arst_n = 1'b0;
        rd_from_ram = 1'b0;
        nvm_wait_cycles = 3'h4;
        pe_req = '0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(negedge sys_clk);
        check("busy_reset", {28'h0, busy}, 32'h0);
        check("rd_data_reset", rd_data, 32'hffffffff);
        for (int i = 0; i < 10; i++)
        begin
            w = (i < 4) ? i + 1 : {$random(seed)} % 4 + 1;
            a = 24'($random(seed));
            a[1:0] = 2'h0;
            @(posedge sys_clk);
            nvm_wait_cycles <= w[2:0];
            master.do_read(a, lat);
            check("lat_nonseq", lat, exp_lat(w, 1'b0));
            check("rd_data", rd_data, nvm_pkg::ERASED_WORD);
            repeat (6) @(posedge sys_clk);
            master.do_read(a + 24'h4, lat);
            check("lat_seq", lat, exp_lat(w, 1'b1));
        end
        master.do_read(24'h400000, lat);
        pe_op(2'h1, 2'h1, 1'b0);
        pe_op(2'h2, 2'h3, 1'b1);
        check("busy_set", {28'h0, busy}, 32'h8);
        pe_op(2'h1, 2'h3, 1'b0);
        drain(2'h3, lat);
        @(posedge sys_clk);
        check("erase_span", span_ok(busy_len[3]), 32'h1);
        @(posedge sys_clk);
        rd_from_ram <= 1'b1;
        for (int t = 0; t < 4; t++)
            pe_op(2'(t % 3 + 1), 2'(t), 1'b1);
        check("busy_all", {28'h0, busy}, 32'hf);
        pe_op(2'h3, 2'h2, 1'b0);
        drain(2'h0, lat);
        @(posedge sys_clk);
        check("prog_span", span_ok(busy_len[0]), 32'h1);
        drain(2'h3, lat);
        check("busy_clear", {28'h0, busy}, 32'h0);
        // request while frozen must leave all state alone
        @(posedge sys_clk);
        clk_en <= 1'b0;
        pe_req <= '{valid: 1'b1, op: nvm_pkg::OP_PROG, target: 2'h0};
        repeat (2) @(posedge sys_clk);
        pe_req <= '{valid: 1'b0, op: nvm_pkg::OP_NONE, target: 2'h0};
        @(posedge sys_clk);
        check("frozen_busy", {28'h0, busy}, 32'h0);
        check("frozen_accept", {31'h0, pe_accept}, 32'h0);
        clk_en <= 1'b1;
        @(posedge sys_clk);
        complete_run;
    end
endmodule
`default_nettype wire
